//--- dv/host_page_src_codec_access_test.sv
// Self-checking bench for the page, converter and codec registers
`timescale 1ns/1ps
module host_page_src_codec_access_test;
  import hpsc_pkg::*;
  logic            clk_i = 1'b0;
  logic            resetn_i = 1'b0;
  hpsc_ahb_in_s    bus = '0;
  hpsc_ahb_in_s    ahb_in;
  hpsc_ahb_out_s   ahb_o;
  logic            tick = 1'b0;
  hpsc_sample_s [2:0] smp = '0;
  hpsc_sample_s [2:0] smp_o;
  logic            req;
  logic            ack;
  logic            req_q = 1'b0;
  logic [3:0]      dly = 4'h8;
  hpsc_codec_cmd_s cmd;
  hpsc_codec_cmd_s cmd_seen;
  logic [15:0]     rdat;
  logic [15:0]     last [3];
  logic [31:0]     d;
  int              fail_count = 0;
  int              total_checks = 0;
  int              reqs = 0;
  int              cnt [3] = '{0, 0, 0};
  int              ex [3] = '{0, 0, 0};
  logic [7:0]  ra [5] = '{8'h0C, 8'h30, 8'h3C, 8'h04, 8'h0C};
  logic [31:0] rw [5] = '{32'h000000A5, 32'h12345678, 32'hCAFEF00D,
                          32'hFFFFFFFF, 32'h00000006};
  logic [31:0] re [5] = '{32'h00000005, 32'h12345678, 32'hCAFEF00D,
                          32'h00000000, 32'h00000006};
  logic [31:0] ctl [4] = '{32'h00200000, 32'h00180000, 32'h00400000,
                           32'h00000000};

  always #12.5 clk_i = ~clk_i;
  always_comb begin
    ahb_in = bus;
    ahb_in.hready = ahb_o.hreadyout;
  end

  hpsc_regs #(.CONV_OP_CYCLES(4)) u_hpsc_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .ahb_i(ahb_in), .ahb_o(ahb_o),
    .tick_i(tick), .sample_i(smp), .sample_o(smp_o), .codec_req_o(req),
    .codec_cmd_o(cmd), .codec_ack_i(ack), .codec_rdata_i(rdat));
  hpsc_codec_model u_hpsc_codec_model (
    .clk_i(clk_i), .resetn_i(resetn_i), .dly_i(dly), .req_i(req),
    .cmd_i(cmd), .ack_o(ack), .rdata_o(rdat));

  // ----------------------------------------------------------------
  // Monitors and tasks
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    for (int c = 0; c < 3; c++) begin
      if (smp_o[c].valid === 1'b1) begin
        cnt[c]++;
        last[c] = smp_o[c].data;
      end
    end
    if (req === 1'b1 && req_q !== 1'b1) begin
      reqs++;
      cmd_seen = cmd;
    end
    req_q = req;
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic lim(input int n);
    if (n >= 40) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [2:0] sz, input logic [31:0] wd);
    int n;
    logic ok;
    bus.hsel <= 1'b1;
    bus.htrans <= 2'b10;
    bus.haddr <= {24'h0, a};
    bus.hwrite <= w;
    bus.hsize <= sz;
    n = 0;
    do begin
      @(negedge clk_i) ok = ahb_o.hreadyout;
      @(posedge clk_i) n++;
    end while (ok !== 1'b1 && n < 40);
    if (ok !== 1'b1) lim(40);
    bus.htrans <= 2'b00;
    bus.hwdata <= wd;
    n = 0;
    do begin
      @(negedge clk_i) ok = ahb_o.hreadyout;
      d = ahb_o.hrdata;
      @(posedge clk_i) n++;
    end while (ok !== 1'b1 && n < 40);
    if (ok !== 1'b1) lim(40);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, 3'h2, v);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 3'h2, 32'h0);
  endtask

  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (d[b] !== 1'b0 && n < 40);
    if (d[b] !== 1'b0) lim(40);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    chk(32'h0, 32'h1);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i]);
      chk(d, re[i]);
      chk({31'h0, ahb_o.hresp}, 32'h0);
    end
    xfer(1'b1, 8'h0C, 3'h0, 32'hFFFFFF05);
    rd(8'h0C);
    chk(d, 32'h00000005);
    rd(8'h30);
    chk(d, 32'h12345678);
    xfer(1'b1, 8'h32, 3'h1, 32'hBEEF0000);
    rd(8'h30);
    chk(d, 32'hBEEF5678);
    $display("Page tests done");
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    foreach (ra[i]) begin
      rd(ra[i] + 8'h4);
      chk(d, 32'h0);
    end
    $display("Reset tests done");
    wr(8'h10, 32'h0B00ABCD);
    rd(8'h10);
    chk({31'h0, d[23]}, 32'h1);
    poll(8'h10, 23);
    wr(8'h10, 32'h0A000000);
    poll(8'h10, 23);
    chk(d, 32'h0A00ABCD);
    for (int c = 0; c < 3; c++) begin
      wr(8'h10, {7'(7'h7D + c), 1'b1, 8'h00, 16'h8000});
      poll(8'h10, 23);
    end
    smp <= '{'{1'b1, 16'hA002}, '{1'b1, 16'hA001}, '{1'b1, 16'hA000}};
    @(posedge clk_i);
    smp <= '{'{1'b0, 16'hA002}, '{1'b0, 16'hA001}, '{1'b0, 16'hA000}};
    foreach (ctl[p]) begin
      wr(8'h10, ctl[p]);
      poll(8'h10, 23);
      repeat (2) begin
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      for (int c = 0; c < 3; c++) begin
        if (!ctl[p][21 - c] && !ctl[p][22])
          ex[c]++;
        chk(cnt[c], ex[c]);
      end
    end
    for (int c = 0; c < 3; c++)
      chk({16'h0, last[c]}, 32'hA000 + c);
    xfer(1'b1, 8'h10, 3'h0, 32'h0B7800FF);
    rd(8'h10);
    chk(d, 32'h0);
    $display("Converter tests done");
    wr(8'h14, 32'h00A60000);
    rd(8'h14);
    chk({30'h0, d[31:30]}, 32'h1);
    poll(8'h14, 30);
    chk(d, 32'h80A6C026);
    rd(8'h14);
    rd(8'h14);
    chk(reqs, 1);
    chk({8'h0, cmd_seen}, 32'h00A60000);
    dly <= 4'h0;
    xfer(1'b1, 8'h14, 3'h0, 32'h00A60000);
    wr(8'h14, 32'h00021234);
    poll(8'h14, 30);
    chk(d, 32'h00021234);
    chk(reqs, 2);
    $display("Codec tests done");
    tally_and_finish();
  end
endmodule // host_page_src_codec_access_test

//--- dv/hpsc_codec_model.sv
// Behavioural codec answering register transactions after a set delay
`timescale 1ns/1ps
module hpsc_codec_model (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  // Transaction side
  input  wire logic [3:0]                dly_i,
  input  wire logic                      req_i,
  input  wire hpsc_pkg::hpsc_codec_cmd_s cmd_i,
  output      logic                      ack_o,
  output      logic [15:0]               rdata_o
);
  import hpsc_pkg::*;
  logic [3:0] cnt;
  // ----------------------------------------------------------------
  // Answer once per request, data toggles while not answering
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt <= 4'h0;
      if (req_i && !ack_o) begin
        cnt <= cnt + 4'h1;
        if (cnt == dly_i) begin
          ack_o <= 1'b1;
          rdata_o <= {9'h180, cmd_i.index};
          cnt <= 4'h0;
        end
      end
    end
  end
endmodule // hpsc_codec_model

//--- verilog/hpsc_params.svh
// Offsets, field positions, reset values and timing counts
`ifndef HPSC_PARAMS_SVH
`define HPSC_PARAMS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HPSC_OFF_PAGE      8'h0C
`define HPSC_OFF_CONV      8'h10
`define HPSC_OFF_CODEC     8'h14
`define HPSC_WIN_NIBBLE    4'h3
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HPSC_CONV_DIR      24
`define HPSC_CONV_OFF      22
`define HPSC_CONV_INH_P1   21
`define HPSC_CONV_INH_P2   20
`define HPSC_CONV_INH_REC  19
`define HPSC_CODEC_DIR     23
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HPSC_PAGE_RESET    4'h0
`define HPSC_WORD_RESET    32'h00000000
// ----------------------------------------------------------------
// Timing counts in host clocks and the increment RAM base index
// ----------------------------------------------------------------
`define HPSC_BUSY_MAX_CLK  3
`define HPSC_CONV_OP_CLK   2
`define HPSC_INC_BASE      7'h7D
`endif

//--- verilog/hpsc_pkg.sv
// Types shared by the host page, converter and codec access block
package hpsc_pkg;

  // ----------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } hpsc_ahb_in_s;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } hpsc_ahb_out_s;

  typedef struct packed {
    logic        dir;
    logic [6:0]  index;
    logic [15:0] value;
  } hpsc_codec_cmd_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } hpsc_sample_s;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HPSC_CV_IDLE = 2'b01,
    HPSC_CV_RUN  = 2'b10
  } hpsc_conv_e;

  typedef enum logic [1:0] {
    HPSC_CD_IDLE = 2'b01,
    HPSC_CD_REQ  = 2'b10
  } hpsc_codec_e;

  typedef struct packed {
    logic                  wr_pend;
    logic                  rd_pend;
    logic [7:0]            dp_addr;
    logic [3:0]            dp_mask;
    logic                  dp_word;
    logic [31:0]           hrdata;
    logic [3:0]            page;
    logic [63:0][31:0]     win_mem;
    hpsc_conv_e            conv_st;
    logic [3:0]            conv_cnt;
    logic [6:0]            conv_index;
    logic                  conv_dir;
    logic [15:0]           conv_value;
    logic                  conv_off;
    logic [2:0]            inhibit;
    logic [127:0][15:0]    conv_ram;
    logic [2:0][15:0]      accum;
    logic [2:0][15:0]      hold;
    hpsc_sample_s [2:0]    out;
    hpsc_codec_e           codec_st;
    hpsc_codec_cmd_s       codec_cmd;
    logic                  codec_ready;
    logic [15:0]           codec_result;
  } hpsc_state_s;

endpackage

//--- verilog/hpsc_regs.sv
// Host page window, rate converter RAM port and codec access registers
//
// Operation
// - Four-bit page picks one of sixteen 16-byte pages seen at 30H-3FH.
// - Page register takes byte, word, longword writes; upper bits masked.
// - Converter port is longword only: RAM index high, RAM value low.
// - Bit 24 picks converter RAM read or write at the given index.
// - Busy rises within three clocks of a longword write to the converter port.
// - Busy stays high until the requested RAM operation completes.
// - Bit 22 high stops rate conversion, low lets it run.
// - Bit 21 high freezes the first playback accumulator.
// - Bit 20 high freezes the second playback accumulator.
// - Bit 19 high freezes the record accumulator.
// - Converter port reads all zeros after power-on.
// - Converter passes samples along, rate-matched to the codec.
// - A longword write at 14H launches one codec register transaction if none is in progress.
// - Ready bit set only when codec read data are held.
// - In-progress bit high while a codec access is outstanding.
// - Codec read view gives direction, index, data; bits 29:24 zero.
// - Reading the codec register never starts a transaction.
`timescale 1ns/1ps
`include "hpsc_params.svh"

module hpsc_regs #(
  parameter int CONV_OP_CYCLES = `HPSC_CONV_OP_CLK
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  // AHB-Lite slave
  input  wire hpsc_pkg::hpsc_ahb_in_s    ahb_i,
  output      hpsc_pkg::hpsc_ahb_out_s   ahb_o,
  // Samples: 0 play one, 1 play two, 2 record
  input  wire logic                      tick_i,
  input  wire hpsc_pkg::hpsc_sample_s [2:0] sample_i,
  output      hpsc_pkg::hpsc_sample_s [2:0] sample_o,
  // Codec register transactions
  output      logic                      codec_req_o,
  output      hpsc_pkg::hpsc_codec_cmd_s codec_cmd_o,
  input  wire logic                      codec_ack_i,
  input  wire logic [15:0]               codec_rdata_i
);
  import hpsc_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CONV_OP_CYCLES < 1 || CONV_OP_CYCLES > 15) begin : g_bad_cycles
    $error("CONV_OP_CYCLES must lie in 1..15");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hpsc_state_s s_reg;
  hpsc_state_s s_next;
  logic        addr_take;
  logic        conv_start;
  logic        codec_start;
  logic        conv_busy;
  logic [3:0]  lane_mask;
  logic [31:0] win_word;
  logic [15:0] ram_at_index;

  assign conv_busy    = (s_reg.conv_st == HPSC_CV_RUN);
  assign win_word     = s_reg.win_mem[{s_reg.page, s_reg.dp_addr[3:2]}];
  assign ram_at_index = s_reg.conv_ram[s_reg.conv_index];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [16:0] sum;
    logic [15:0] inc;
    logic [5:0]  widx;
    sum         = 17'h00000;
    inc         = 16'h0000;
    widx        = 6'h00;
    s_next      = s_reg;
    conv_start  = 1'b0;
    codec_start = 1'b0;
    addr_take   = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    unique case (ahb_i.hsize)
      3'h0:    lane_mask = 4'h1 << ahb_i.haddr[1:0];
      3'h1:    lane_mask = ahb_i.haddr[1] ? 4'hC : 4'h3;
      default: lane_mask = 4'hF;
    endcase

    // Bus address phase
    s_next.wr_pend = addr_take && ahb_i.hwrite;
    s_next.rd_pend = addr_take && !ahb_i.hwrite;
    if (addr_take) begin
      s_next.dp_addr = ahb_i.haddr[7:0];
      s_next.dp_mask = lane_mask;
      s_next.dp_word = (ahb_i.hsize == 3'h2);
    end

    // Converter RAM engine
    unique case (s_reg.conv_st)
      HPSC_CV_IDLE: begin
      end
      HPSC_CV_RUN: begin
        if (s_reg.conv_cnt == 4'h0) begin
          if (s_reg.conv_dir) begin
            s_next.conv_ram[s_reg.conv_index] = s_reg.conv_value;
          end else begin
            s_next.conv_value = s_reg.conv_ram[s_reg.conv_index];
          end
          s_next.conv_st = HPSC_CV_IDLE;
        end else begin
          s_next.conv_cnt = s_reg.conv_cnt - 4'h1;
        end
      end
    endcase

    // Codec transaction
    unique case (s_reg.codec_st)
      HPSC_CD_IDLE: begin
      end
      HPSC_CD_REQ: begin
        if (codec_ack_i) begin
          s_next.codec_st = HPSC_CD_IDLE;
          if (s_reg.codec_cmd.dir) begin
            s_next.codec_result = codec_rdata_i;
            s_next.codec_ready  = 1'b1;
          end else begin
            s_next.codec_result = s_reg.codec_cmd.value;
          end
        end
      end
    endcase

    // Bus data phase writes
    if (s_reg.wr_pend) begin
      if (s_reg.dp_addr == `HPSC_OFF_PAGE && s_reg.dp_mask[0]) begin
        s_next.page = ahb_i.hwdata[3:0];
      end
      if (s_reg.dp_addr[7:4] == `HPSC_WIN_NIBBLE) begin
        widx = {s_reg.page, s_reg.dp_addr[3:2]};
        for (int b = 0; b < 4; b++) begin
          if (s_reg.dp_mask[b]) begin
            s_next.win_mem[widx][8*b +: 8] = ahb_i.hwdata[8*b +: 8];
          end
        end
      end
      if (s_reg.dp_addr == `HPSC_OFF_CONV && s_reg.dp_word) begin
        s_next.conv_off   = ahb_i.hwdata[`HPSC_CONV_OFF];
        s_next.inhibit[0] = ahb_i.hwdata[`HPSC_CONV_INH_P1];
        s_next.inhibit[1] = ahb_i.hwdata[`HPSC_CONV_INH_P2];
        s_next.inhibit[2] = ahb_i.hwdata[`HPSC_CONV_INH_REC];
        if (s_reg.conv_st == HPSC_CV_IDLE) begin
          conv_start        = 1'b1;
          s_next.conv_st    = HPSC_CV_RUN;
          s_next.conv_cnt   = 4'(CONV_OP_CYCLES - 1);
          s_next.conv_index = ahb_i.hwdata[31:25];
          s_next.conv_dir   = ahb_i.hwdata[`HPSC_CONV_DIR];
          s_next.conv_value = ahb_i.hwdata[15:0];
        end
      end
      if (s_reg.dp_addr == `HPSC_OFF_CODEC && s_reg.dp_word &&
          s_reg.codec_st == HPSC_CD_IDLE) begin
        codec_start            = 1'b1;
        s_next.codec_st        = HPSC_CD_REQ;
        s_next.codec_cmd.dir   = ahb_i.hwdata[`HPSC_CODEC_DIR];
        s_next.codec_cmd.index = ahb_i.hwdata[22:16];
        s_next.codec_cmd.value = ahb_i.hwdata[15:0];
        s_next.codec_ready     = 1'b0;
      end
    end

    // Bus data phase reads, loaded in the one wait state
    if (s_reg.rd_pend) begin
      s_next.hrdata = `HPSC_WORD_RESET;
      if (s_reg.dp_addr[7:4] == `HPSC_WIN_NIBBLE) begin
        s_next.hrdata = win_word;
      end else if (s_reg.dp_addr == `HPSC_OFF_PAGE) begin
        s_next.hrdata = {28'h0000000, s_reg.page};
      end else if (s_reg.dp_addr == `HPSC_OFF_CONV) begin
        s_next.hrdata = {s_reg.conv_index, s_reg.conv_dir, conv_busy,
                         s_reg.conv_off, s_reg.inhibit[0],
                         s_reg.inhibit[1], s_reg.inhibit[2], 3'h0,
                         s_reg.conv_value};
      end else if (s_reg.dp_addr == `HPSC_OFF_CODEC) begin
        s_next.hrdata = {s_reg.codec_ready,
                         (s_reg.codec_st == HPSC_CD_REQ), 6'h00,
                         s_reg.codec_cmd.dir, s_reg.codec_cmd.index,
                         s_reg.codec_result};
      end
    end

    // Rate conversion per channel
    for (int c = 0; c < 3; c++) begin
      s_next.out[c].valid = 1'b0;
      if (sample_i[c].valid) begin
        s_next.hold[c] = sample_i[c].data;
      end
      if (tick_i && !s_reg.conv_off && !s_reg.inhibit[c]) begin
        inc = s_reg.conv_ram[`HPSC_INC_BASE + 7'(c)];
        sum = {1'b0, s_reg.accum[c]} + {1'b0, inc};
        s_next.accum[c] = sum[15:0];
        if (sum[16]) begin
          s_next.out[c].valid = 1'b1;
          s_next.out[c].data  = s_reg.hold[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg          <= '0;
      s_reg.page     <= `HPSC_PAGE_RESET;
      s_reg.conv_st  <= HPSC_CV_IDLE;
      s_reg.codec_st <= HPSC_CD_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ahb_o.hreadyout = !s_reg.rd_pend;
  assign ahb_o.hresp     = 1'b0;
  assign ahb_o.hrdata    = s_reg.hrdata;
  assign sample_o        = s_reg.out;
  assign codec_req_o     = (s_reg.codec_st == HPSC_CD_REQ);
  assign codec_cmd_o     = s_reg.codec_cmd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_window_page_map: assert property (
    s_reg.rd_pend && s_reg.dp_addr[7:4] == `HPSC_WIN_NIBBLE
    |=> s_reg.hrdata == $past(win_word))
    else $error("window read misses selected page");

  a_page_value_hold: assert property (
    s_reg.wr_pend && s_reg.dp_addr == `HPSC_OFF_PAGE && s_reg.dp_mask[0]
    |=> s_reg.page == $past(ahb_i.hwdata[3:0]))
    else $error("page register did not take written value");

  a_conv_word_only: assert property (
    s_reg.wr_pend && s_reg.dp_addr == `HPSC_OFF_CONV && !s_reg.dp_word
    |=> !$rose(conv_busy) && $stable(s_reg.conv_off) &&
        $stable(s_reg.inhibit))
    else $error("narrow converter write took effect");

  a_busy_rise_time: assert property (
    addr_take && ahb_i.hwrite && ahb_i.hsize == 3'h2 &&
    ahb_i.haddr[7:0] == `HPSC_OFF_CONV && !conv_busy
    |-> ##[1:3] conv_busy)
    else $error("busy not raised within three clocks");

  a_busy_until_done: assert property (
    $fell(conv_busy) |-> $past(s_reg.conv_cnt) == 4'h0)
    else $error("busy cleared before RAM operation ended");

  a_ram_dir_effect: assert property (
    $fell(conv_busy) |-> ram_at_index == s_reg.conv_value)
    else $error("RAM operation did not follow direction bit");

  a_conv_stop_all: assert property (
    s_reg.conv_off |=> s_reg.out[0].valid == 1'b0 &&
    s_reg.out[1].valid == 1'b0 && s_reg.out[2].valid == 1'b0)
    else $error("converter produced samples while stopped");

  a_inhibit_play_one: assert property (
    s_reg.inhibit[0] |=> $stable(s_reg.accum[0]))
    else $error("play one accumulator moved while inhibited");

  a_inhibit_play_two: assert property (
    s_reg.inhibit[1] |=> $stable(s_reg.accum[1]))
    else $error("play two accumulator moved while inhibited");

  a_inhibit_record: assert property (
    s_reg.inhibit[2] |=> $stable(s_reg.accum[2]))
    else $error("record accumulator moved while inhibited");

  a_sample_on_tick: assert property (
    s_reg.out[0].valid || s_reg.out[1].valid || s_reg.out[2].valid
    |-> $past(tick_i) && !$past(s_reg.conv_off))
    else $error("sample produced without a tick");

  a_codec_launch: assert property (
    codec_start |=> codec_req_o && s_reg.codec_ready == 1'b0)
    else $error("codec write did not launch a transaction");

  a_codec_ready_set: assert property (
    $rose(s_reg.codec_ready)
    |-> $past(codec_ack_i) && $past(s_reg.codec_cmd.dir))
    else $error("ready set without returned read data");

  a_codec_view_bits: assert property (
    s_reg.rd_pend && s_reg.dp_addr == `HPSC_OFF_CODEC
    |=> s_reg.hrdata[29:24] == 6'h00 &&
        s_reg.hrdata[30] == $past(codec_req_o))
    else $error("codec read view malformed");

  a_codec_read_idle: assert property (
    s_reg.rd_pend && !codec_req_o |=> !codec_req_o)
    else $error("codec read started a transaction");

  a_page_read_view: assert property (
    s_reg.rd_pend && s_reg.dp_addr == `HPSC_OFF_PAGE
    |=> s_reg.hrdata == {28'h0000000, $past(s_reg.page)})
    else $error("page read view malformed");

  a_window_write: assert property (
    s_reg.wr_pend && s_reg.dp_addr[7:4] == `HPSC_WIN_NIBBLE &&
    s_reg.dp_mask == 4'hF
    |=> s_reg.win_mem[$past({s_reg.page, s_reg.dp_addr[3:2]})] ==
        $past(ahb_i.hwdata))
    else $error("window write missed selected page");

  a_conv_view_bits: assert property (
    s_reg.rd_pend && s_reg.dp_addr == `HPSC_OFF_CONV
    |=> s_reg.hrdata[18:16] == 3'h0 &&
        s_reg.hrdata[23] == $past(conv_busy))
    else $error("converter read view malformed");

  a_busy_hold_count: assert property (
    conv_busy && s_reg.conv_cnt != 4'h0 |=> conv_busy)
    else $error("busy cleared with cycles left");

  a_busy_write_refused: assert property (
    s_reg.wr_pend && s_reg.dp_addr == `HPSC_OFF_CONV && conv_busy
    |=> $stable(s_reg.conv_index) && $stable(s_reg.conv_dir))
    else $error("converter write while busy restarted RAM op");

  a_ram_read_value: assert property (
    conv_busy && s_reg.conv_cnt == 4'h0 && !s_reg.conv_dir
    |=> s_reg.conv_value == $past(ram_at_index))
    else $error("RAM read did not load value field");

  a_ram_write_value: assert property (
    conv_busy && s_reg.conv_cnt == 4'h0 && s_reg.conv_dir
    |=> ram_at_index == $past(s_reg.conv_value))
    else $error("RAM write did not store value field");

  a_off_bit_take: assert property (
    s_reg.wr_pend && s_reg.dp_addr == `HPSC_OFF_CONV && s_reg.dp_word
    |=> s_reg.conv_off == $past(ahb_i.hwdata[`HPSC_CONV_OFF]))
    else $error("converter stop bit not taken");

  a_inhibit_bits_take: assert property (
    s_reg.wr_pend && s_reg.dp_addr == `HPSC_OFF_CONV && s_reg.dp_word
    |=> s_reg.inhibit[0] == $past(ahb_i.hwdata[`HPSC_CONV_INH_P1]) &&
        s_reg.inhibit[1] == $past(ahb_i.hwdata[`HPSC_CONV_INH_P2]) &&
        s_reg.inhibit[2] == $past(ahb_i.hwdata[`HPSC_CONV_INH_REC]))
    else $error("accumulator inhibit bits not taken");

  a_sample_data_hold: assert property (
    s_reg.out[0].valid |-> s_reg.out[0].data == $past(s_reg.hold[0]))
    else $error("play one sample data not the held sample");

  a_codec_cmd_steady: assert property (
    codec_req_o |=> $stable(codec_cmd_o))
    else $error("codec command changed while requested");

  a_codec_done_idle: assert property (
    codec_req_o && codec_ack_i |=> !codec_req_o)
    else $error("in-progress stayed high after answer");

  a_codec_read_result: assert property (
    codec_req_o && codec_ack_i && codec_cmd_o.dir
    |=> s_reg.codec_ready && s_reg.codec_result == $past(codec_rdata_i))
    else $error("codec read result not captured");

  a_codec_write_result: assert property (
    codec_req_o && codec_ack_i && !codec_cmd_o.dir
    |=> !s_reg.codec_ready &&
        s_reg.codec_result == $past(codec_cmd_o.value))
    else $error("codec write result malformed");

endmodule // hpsc_regs
